// file: inc/css_pkg.sv
// types for the converter start-up sequencer
package css_pkg;
	typedef enum logic [3:0] {
		CSS_CAL_IDLE = 4'b0001,
		CSS_CAL_WAIT = 4'b0010,
		CSS_CAL_RUN = 4'b0100,
		CSS_CAL_DONE = 4'b1000
	} css_cal_state_t;
endpackage : css_pkg

// file: inc/css_regs.svh
// register offsets, field values, reset values and timing counts
`ifndef CSS_REGS_SVH
`define CSS_REGS_SVH

`define CSS_ADDR_W 8
`define CSS_REG_INIT 8'h00
`define CSS_REG_PLL 8'h04
`define CSS_REG_DIV 8'h08
`define CSS_REG_LINK 8'h0C
`define CSS_REG_CAL 8'h10
`define CSS_REG_TRIG 8'h14
`define CSS_REG_AUX 8'h18
`define CSS_REG_OVR 8'h1C
`define CSS_REG_STAT 8'h20

`define CSS_OSC_BIAS_RST 8'h00
`define CSS_OSC_BIAS_NOM 8'h4A
`define CSS_AUX_DIV32 8'h81
`define CSS_AUX_DIV_N 32
`define CSS_PLL_RST 32'h0000_0001
`define CSS_INIT_CYCLES 16
`define CSS_TRIM_CYCLES 64
`define CSS_LOCK_CYCLES 64
`define CSS_FG_CAL_CYCLES 256

`endif

// file: src/css_sequencer.sv
// start-up and calibration sequencer with wishbone register slave
//
// Contract
// - clearing pll hold starts trim, enables pll
// - clearing link enable halts link engine
// - clearing cal enable halts cal engine
// - aux control 0x81 gives lane rate/32
// - setting link enable restarts link engine
// - software trigger rising edge starts calibration when background cal is clear
// - pin trigger rising edge starts calibration when background cal is clear
// - completion raises status pin and done bit
// - sync used only in 8b/10b modes
`timescale 1ns/100ps
`include "css_regs.svh"

module css_sequencer #(
	parameter int INIT_CYCLES = `CSS_INIT_CYCLES,
	parameter int TRIM_CYCLES = `CSS_TRIM_CYCLES,
	parameter int LOCK_CYCLES = `CSS_LOCK_CYCLES,
	parameter int CAL_CYCLES = `CSS_FG_CAL_CYCLES
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic pll_enable_strap,
	input wire logic cal_trigger_pin,
	input wire logic sync_single_ended_pin,
	input wire logic timestamp_pair,
	input wire logic lane_clk_en,
	output logic cal_status_pin,
	output logic aux_diff_clock_output,
	output logic link_run,
	output logic link_sync_req,
	output logic pll_run,
	output logic cal_run
);
	logic [5:0] init_cnt;
	logic init_done;
	logic converter_pll_hold;
	logic osc_autotrim_enable;
	logic [7:0] osc_bias_field;
	logic [7:0] osc_trim_field;
	logic [23:0] pll_div;
	logic serial_link_enable;
	logic [4:0] link_mode_select;
	logic [7:0] multiframe_len_minus_one;
	logic sync_sel;
	logic cal_engine_enable;
	logic cal_background;
	logic cal_offset_en;
	logic cal_software_trigger;
	logic cal_pin_trigger_enable;
	logic [7:0] aux_diff_clock_control;
	logic overrange_enable;
	logic osc_trim_complete_flag;
	logic converter_pll_lock_flag;
	logic foreground_cal_complete;
	logic [15:0] pll_cnt;
	logic [15:0] cal_cnt;
	logic [4:0] aux_div;
	logic trig_s1;
	logic trig_s2;
	logic trig_d;
	logic sync_a1;
	logic sync_a2;
	logic sync_b1;
	logic sync_b2;
	logic sw_trig_d;
	css_pkg::css_cal_state_t cal_state;
	css_pkg::css_cal_state_t next_cal_state;

	// bus decode
	wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire wr = bus_req & wb_we_i & wb_sel_i[0];
	wire wr_hi = bus_req & wb_we_i & (&wb_sel_i[2:1]);
	wire wr_init = wr & (wb_adr_i == `CSS_REG_INIT);
	wire wr_pll = wr & (wb_adr_i == `CSS_REG_PLL);
	wire wr_div = wr_hi & wb_sel_i[0] & (wb_adr_i == `CSS_REG_DIV);
	wire wr_link = wr & (wb_adr_i == `CSS_REG_LINK);
	wire wr_cal = wr & (wb_adr_i == `CSS_REG_CAL);
	wire wr_trig = wr & (wb_adr_i == `CSS_REG_TRIG);
	wire wr_aux = wr & (wb_adr_i == `CSS_REG_AUX);
	wire wr_ovr = wr & (wb_adr_i == `CSS_REG_OVR);
	wire mode_8b10b = link_mode_select[4];
	// pin trigger rising edge
	wire pin_rise = cal_pin_trigger_enable & trig_s2 & ~trig_d;
	// software trigger rising edge
	wire sw_rise = cal_software_trigger & ~sw_trig_d;
	wire cal_start = (pin_rise | sw_rise) & ~cal_background;

	logic [31:0] rd_mux;
	always_comb
	begin
		case (wb_adr_i)
			`CSS_REG_INIT: rd_mux = {31'h0000_0000, init_done};
			`CSS_REG_PLL: rd_mux = {8'h00, osc_trim_field, osc_bias_field,
				6'h00, osc_autotrim_enable, converter_pll_hold};
			`CSS_REG_DIV: rd_mux = {8'h00, pll_div};
			`CSS_REG_LINK: rd_mux = {16'h0000, multiframe_len_minus_one,
				1'b0, sync_sel, link_mode_select, serial_link_enable};
			`CSS_REG_CAL: rd_mux = {28'h000_0000, cal_offset_en,
				cal_background, 1'b0, cal_engine_enable};
			`CSS_REG_TRIG: rd_mux = {30'h0000_0000, cal_pin_trigger_enable,
				cal_software_trigger};
			`CSS_REG_AUX: rd_mux = {24'h00_0000, aux_diff_clock_control};
			`CSS_REG_OVR: rd_mux = {31'h0000_0000, overrange_enable};
			`CSS_REG_STAT: rd_mux = {29'h0000_0000, foreground_cal_complete,
				converter_pll_lock_flag, osc_trim_complete_flag};
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end
		else
		begin
			wb_ack_o <= bus_req;
			wb_dat_o <= bus_req ? rd_mux : 32'h0000_0000;
		end
	end

	// init counter, restarted by software reset write
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n || (wr_init && wb_dat_i[0]))
		begin
			init_cnt <= 6'h00;
			init_done <= 1'b0;
		end
		else if (init_cnt == 6'(INIT_CYCLES - 1))
			init_done <= 1'b1;
		else
			init_cnt <= init_cnt + 6'h01;
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n || (wr_init && wb_dat_i[0]))
		begin
			converter_pll_hold <= 1'b1;
			osc_autotrim_enable <= 1'b1;
			osc_bias_field <= `CSS_OSC_BIAS_RST;
			osc_trim_field <= 8'h00;
			pll_div <= 24'h00_0000;
			serial_link_enable <= 1'b1;
			link_mode_select <= 5'h00;
			multiframe_len_minus_one <= 8'h00;
			sync_sel <= 1'b0;
			cal_engine_enable <= 1'b1;
			cal_background <= 1'b0;
			cal_offset_en <= 1'b0;
			cal_software_trigger <= 1'b0;
			cal_pin_trigger_enable <= 1'b0;
			aux_diff_clock_control <= 8'h00;
			overrange_enable <= 1'b0;
		end
		else
		begin
			if (wr_pll)
			begin
				converter_pll_hold <= wb_dat_i[0];
				osc_autotrim_enable <= wb_dat_i[1];
				osc_bias_field <= wb_dat_i[15:8];
				osc_trim_field <= wb_dat_i[23:16];
			end
			if (wr_div)
				pll_div <= wb_dat_i[23:0];
			if (wr_link)
			begin
				serial_link_enable <= wb_dat_i[0];
				// mode and K-1 change only while halted
				if (!serial_link_enable)
				begin
					link_mode_select <= wb_dat_i[5:1];
					sync_sel <= wb_dat_i[6];
					multiframe_len_minus_one <= wb_dat_i[15:8];
				end
			end
			if (wr_cal)
			begin
				cal_engine_enable <= wb_dat_i[0];
				if (!cal_engine_enable)
				begin
					cal_background <= wb_dat_i[2];
					cal_offset_en <= wb_dat_i[3];
				end
			end
			if (wr_trig)
			begin
				cal_software_trigger <= wb_dat_i[0];
				cal_pin_trigger_enable <= wb_dat_i[1];
			end
			if (wr_aux)
				aux_diff_clock_control <= wb_dat_i[7:0];
			if (wr_ovr)
				overrange_enable <= wb_dat_i[0];
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n || converter_pll_hold || !pll_enable_strap)
		begin
			pll_cnt <= 16'h0000;
			osc_trim_complete_flag <= 1'b0;
			converter_pll_lock_flag <= 1'b0;
		end
		else
		begin
			if (pll_cnt != 16'hFFFF)
				pll_cnt <= pll_cnt + 16'h0001;
			if (pll_cnt == 16'(TRIM_CYCLES - 1) || !osc_autotrim_enable)
				osc_trim_complete_flag <= 1'b1;
			if (pll_cnt == 16'(TRIM_CYCLES + LOCK_CYCLES - 1))
				converter_pll_lock_flag <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			trig_s1 <= 1'b0;
			trig_s2 <= 1'b0;
			trig_d <= 1'b0;
			sync_a1 <= 1'b1;
			sync_a2 <= 1'b1;
			sync_b1 <= 1'b1;
			sync_b2 <= 1'b1;
			sw_trig_d <= 1'b0;
		end
		else
		begin
			trig_s1 <= cal_trigger_pin;
			trig_s2 <= trig_s1;
			trig_d <= trig_s2;
			sync_a1 <= sync_single_ended_pin;
			sync_a2 <= sync_a1;
			sync_b1 <= timestamp_pair;
			sync_b2 <= sync_b1;
			sw_trig_d <= cal_software_trigger;
		end
	end

	always_comb
	begin
		next_cal_state = cal_state;
		case (cal_state)
			css_pkg::CSS_CAL_IDLE:
				next_cal_state = css_pkg::CSS_CAL_WAIT;
			css_pkg::CSS_CAL_WAIT:
				if (cal_start)
					next_cal_state = css_pkg::CSS_CAL_RUN;
			css_pkg::CSS_CAL_RUN:
				if (cal_cnt == 16'(CAL_CYCLES - 1))
					next_cal_state = css_pkg::CSS_CAL_DONE;
			css_pkg::CSS_CAL_DONE:
				if (cal_start)
					next_cal_state = css_pkg::CSS_CAL_RUN;
			default:
				next_cal_state = css_pkg::CSS_CAL_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n || !cal_engine_enable)
		begin
			cal_state <= css_pkg::CSS_CAL_IDLE;
			cal_cnt <= 16'h0000;
			foreground_cal_complete <= 1'b0;
			cal_status_pin <= 1'b0;
		end
		else
		begin
			cal_state <= next_cal_state;
			cal_cnt <= (cal_state == css_pkg::CSS_CAL_RUN) ?
				cal_cnt + 16'h0001 : 16'h0000;
			if (next_cal_state == css_pkg::CSS_CAL_DONE)
			begin
				foreground_cal_complete <= 1'b1;
				cal_status_pin <= 1'b1;
			end
			else if (next_cal_state == css_pkg::CSS_CAL_RUN)
			begin
				foreground_cal_complete <= 1'b0;
				cal_status_pin <= 1'b0;
			end
		end
	end

	// aux clock divide by 32 of lane rate
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n || aux_diff_clock_control != `CSS_AUX_DIV32)
		begin
			aux_div <= 5'h00;
			aux_diff_clock_output <= 1'b0;
		end
		else if (lane_clk_en)
		begin
			aux_div <= aux_div + 5'h01;
			if (aux_div == 5'(`CSS_AUX_DIV_N / 2 - 1) || aux_div == 5'h1F)
				aux_diff_clock_output <= ~aux_diff_clock_output;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			link_run <= 1'b0;
			link_sync_req <= 1'b0;
			pll_run <= 1'b0;
			cal_run <= 1'b0;
		end
		else
		begin
			link_run <= serial_link_enable & init_done;
			link_sync_req <= serial_link_enable & mode_8b10b &
				~(sync_sel ? sync_b2 : sync_a2);
			pll_run <= pll_enable_strap & ~converter_pll_hold;
			cal_run <= cal_state == css_pkg::CSS_CAL_RUN;
		end
	end
endmodule : css_sequencer

// file: testbench/css_rx_model.sv
// far-side receiver model: sync request and lane ticks
`timescale 1ns/100ps
module css_rx_model (
	input wire logic sys_clk,
	input wire logic link_run,
	output logic sync_single_ended_pin = 1'h1,
	output logic timestamp_pair = 1'h1,
	output logic lane_clk_en = 1'h0
);
	logic was_run = 1'h0;
	int wait_cnt = 0;
	always @(posedge sys_clk)
	begin
		was_run <= link_run;
		lane_clk_en <= ~lane_clk_en;
		wait_cnt <= (link_run && !was_run) ? 16 : wait_cnt - (wait_cnt > 0);
		sync_single_ended_pin <= wait_cnt == 0 && !(link_run && !was_run);
		timestamp_pair <= wait_cnt == 0 && !(link_run && !was_run);
	end
endmodule : css_rx_model

// file: testbench/css_sequencer_checker.sv
// port checks for the start-up sequencer
`timescale 1ns/100ps
module css_sequencer_checker #(
	parameter int INIT_CYCLES = 16,
	parameter int TRIM_CYCLES = 64,
	parameter int LOCK_CYCLES = 64,
	parameter int CAL_CYCLES = 256
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic wb_ack_o,
	input wire logic pll_enable_strap,
	input wire logic sync_single_ended_pin,
	input wire logic timestamp_pair,
	input wire logic lane_clk_en,
	input wire logic cal_status_pin,
	input wire logic aux_diff_clock_output,
	input wire logic link_run,
	input wire logic link_sync_req,
	input wire logic pll_run,
	input wire logic cal_run
);
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);
	sequence s_wr;
		wb_ack_o && wb_we_i && wb_sel_i[0];
	endsequence
	sequence s_clr(logic [7:0] a);
		s_wr ##0 (wb_adr_i == a && !wb_dat_i[0]);
	endsequence
	AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
		|=> wb_ack_o) else $error("ack missing");
	AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack too long");
	AST_LINK_HALT: assert property (
		s_clr(8'h0C) |-> ##[0:2] !link_run) else $error("link runs");
	AST_CAL_HALT: assert property (
		s_clr(8'h10) |-> ##[0:2] (!cal_run && !cal_status_pin))
		else $error("cal not halted");
	AST_PLL_START: assert property (
		s_clr(8'h04) ##0 pll_enable_strap |-> ##[0:2] pll_run)
		else $error("pll not started");
	AST_SYNC_IDLE: assert property (
		(sync_single_ended_pin && timestamp_pair)[*5] |-> !link_sync_req)
		else $error("sync request stuck");
	AST_AUX_TICK: assert property (
		$rose(aux_diff_clock_output) |-> $past(lane_clk_en))
		else $error("aux edge off tick");
	AST_CAL_DONE: assert property (
		$rose(cal_status_pin) |-> $past(cal_run) || $past(cal_run, 2))
		else $error("done without run");
endmodule : css_sequencer_checker

bind css_sequencer css_sequencer_checker #(.INIT_CYCLES(INIT_CYCLES),
	.TRIM_CYCLES(TRIM_CYCLES), .LOCK_CYCLES(LOCK_CYCLES),
	.CAL_CYCLES(CAL_CYCLES)) i_chk (.*);

// file: testbench/css_sequencer_tb.sv
// self-checking bench for the start-up sequencer
`timescale 1ns/100ps
module css_sequencer_tb;
	logic sys_clk = '0, rst_n = '0, wb_cyc_i = '0, wb_stb_i = '0;
	logic wb_we_i = '0, cal_trigger_pin = '1;
	logic pll_enable_strap = '1;
	int n;
	logic [7:0] wb_adr_i = '0;
	logic [3:0] wb_sel_i = '0;
	logic [31:0] wb_dat_i = '0, wb_dat_o, rd, k, lw, seed = 32'h8e1a_c46a;
	logic wb_ack_o, sync_single_ended_pin, timestamp_pair, lane_clk_en;
	logic cal_status_pin, aux_diff_clock_output, link_run, link_sync_req;
	logic pll_run, cal_run;
	logic [63:0] e, exp_q[$];
	int failures = 0, check_count = 0;
	css_sequencer #(.INIT_CYCLES(4), .TRIM_CYCLES(4), .LOCK_CYCLES(4),
		.CAL_CYCLES(4)) i_dut (.*);
	css_rx_model i_rx (.*);
	always #20 sys_clk = ~sys_clk;
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int c;
		c = 0;
		wb_cyc_i <= '1;
		wb_stb_i <= '1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_sel_i <= 4'hF;
		wb_dat_i <= d;
		do
		begin
			@(posedge sys_clk);
			c++;
		end
		while (wb_ack_o !== 1'h1 && c < 50);
		if (c >= 50)
			pin(1'h0, 1'h1);
		rd = wb_dat_o;
		wb_cyc_i <= '0;
		wb_stb_i <= '0;
		@(posedge sys_clk);
	endtask : wb
	task automatic chk(input logic [7:0] a, input logic [31:0] m, x);
		exp_q.push_back({m, x});
		wb('0, a, '0);
	endtask : chk
	task automatic pin(input logic s, input logic x);
		check_count++;
		if (s !== x)
		begin
			failures++;
			$display("mismatch pin expected %b seen %b", x, s);
		end
	endtask : pin
	task automatic poll(input logic [7:0] a, input logic [31:0] m);
		int c;
		c = 0;
		do
		begin
			wb('0, a, '0);
			c++;
		end
		while ((rd & m) !== m && c < 100);
		pin((rd & m) === m, 1'h1);
	endtask : poll
	task automatic wt(ref logic s);
		int c;
		c = 0;
		while (s !== 1'h1 && c < 500)
		begin
			@(posedge sys_clk);
			c++;
		end
		if (c >= 500)
			pin(1'h0, 1'h1);
	endtask : wt
	task automatic report_and_stop();
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : report_and_stop
	always @(posedge sys_clk)
		if (wb_ack_o === 1'h1 && wb_we_i === 1'h0 && exp_q.size() > 0)
		begin
			e = exp_q.pop_front();
			check_count++;
			if ((wb_dat_o & e[63:32]) !== e[31:0])
			begin
				failures++;
				$display("mismatch read data expected %h seen %h", e[31:0],
					wb_dat_o & e[63:32]);
			end
		end
	initial
	begin
		#200000;
		failures++;
		report_and_stop();
	end
	initial
	begin
		// clock runs and no power-down during reset
		repeat (5) @(posedge sys_clk);
		rst_n <= '1;
		// steps below run in the listed order
		@(posedge sys_clk);
		chk(8'h10, 32'hFFFF_FFFF, 32'h0000_0001);
		wb('1, 8'h00, 32'h0000_0001);
		poll(8'h00, 32'h0000_0001);
		wb('1, 8'h04, 32'h0000_4A03);
		k = rnd();
		wb('1, 8'h08, {8'h00, k[23:0]});
		chk(8'h08, 32'h00FF_FFFF, {8'h00, k[23:0]});
		chk(8'h04, 32'h00FF_FF03, 32'h0000_4A03);
		wb('1, 8'h04, 32'h0000_4A02);
		poll(8'h20, 32'h0000_0003);
		wb('1, 8'h0C, 32'h0000_0000);
		wb('1, 8'h10, 32'h0000_0000);
		lw = {16'h0000, k[31:24], 8'h21};
		wb('1, 8'h18, 32'h0000_0081);
		wt(aux_diff_clock_output);
		n = 0;
		while (aux_diff_clock_output === 1'h1 && n < 100)
		begin
			@(posedge sys_clk);
			n++;
		end
		pin(n == 32, 1'h1);
		wb('1, 8'h10, 32'h0000_0001);
		wb('1, 8'h1C, 32'h0000_0001);
		wb('1, 8'h0C, lw);
		wt(link_run);
		repeat (6) @(posedge sys_clk);
		pin(link_sync_req, 1'h1);
		wb('1, 8'h0C, 32'h0000_0003);
		chk(8'h0C, 32'h0000_FFFF, lw);
		wb('1, 8'h0C, 32'h0000_0000);
		wb('1, 8'h0C, 32'h0000_0001);
		repeat (6) @(posedge sys_clk);
		pin(link_sync_req, 1'h0);
		wb('1, 8'h14, 32'h0000_0000);
		wb('1, 8'h14, 32'h0000_0001);
		wt(cal_status_pin);
		pin(cal_status_pin, 1'h1);
		chk(8'h20, 32'h0000_0004, 32'h0000_0004);
		wb('1, 8'h14, 32'h0000_0002);
		cal_trigger_pin <= '0;
		repeat (4) @(posedge sys_clk);
		cal_trigger_pin <= '1;
		wt(cal_run);
		pin(cal_status_pin, 1'h0);
		wt(cal_status_pin);
		chk(8'h20, 32'h0000_0004, 32'h0000_0004);
		wb('1, 8'h10, 32'h0000_0000);
		@(posedge sys_clk);
		pin(cal_status_pin, 1'h0);
		wb('1, 8'h3C, rnd());
		chk(8'h3C, 32'hFFFF_FFFF, 32'h0000_0000);
		report_and_stop();
	end
endmodule : css_sequencer_tb
